// *** scd_asserts.sv ***
// Protocol and ordering checks on the register link between the two ends.
`include "scd_cfg.svh"
module scd_asserts
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access");
    chk_ready_single: assert property (pready |-> psel && penable ##1 !pready && !penable)
        else $error("ready not one cycle");
    chk_request_held: assert property (psel && penable && !pready |=> $stable({paddr, pwrite, pwdata}))
        else $error("request changed");
    chk_setup_first: assert property ($rose(penable) |-> psel && $past(psel && !penable))
        else $error("access without setup");
    chk_div_legal: assert property (pready && !pwrite && paddr == `SCD_REG_DIVIDER |-> !pslverr &&
        prdata inside {32'h1, 32'h2, 32'h4, 32'h8, 32'ha, 32'h10, 32'h14, 32'h28, 32'h32, 32'h50, 32'h64,
        32'hc8, 32'h190, 32'h1f4, 32'h320, 32'h3e8, 32'h7d0})
        else $error("divider off list");
    chk_delay_readable: assert property (pready && !pwrite && paddr == `SCD_REG_STARTDELAY |-> !pslverr)
        else $error("delay read refused");
    chk_rate_then_div: assert property (pready && pwrite && paddr == `SCD_REG_CONFIG |->
        ##[1:4] psel && pwrite && paddr == `SCD_REG_DIVIDER)
        else $error("divider not after rate");
    chk_div_read_back: assert property (pready && pwrite && paddr == `SCD_REG_DIVIDER |->
        ##[1:4] psel && !pwrite && paddr == `SCD_REG_DIVIDER)
        else $error("divider not read back");
endmodule

// *** scd_board.sv ***
// Board end: extra sync divider, start delay report and APB register slave.
//
// Design decision made here: the APB slave port.
`include "scd_cfg.svh"
module scd_board
#(
    parameter logic [31:0] START_DELAY = 32'h0000_0010,
    parameter logic [31:0] SYNC_RATE = 32'h0262_5a00
)
(
    input wire logic clk,
    input wire logic rst_n,
    scd_if.board bus,
    input wire logic fifoMode,
    output logic sampleEn,
    output logic [31:0] activeDiv
);
    typedef struct packed {
        logic [31:0] divider;
        logic [31:0] rate;
        logic [31:0] count;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic en;
    } scd_board_st_t;

    scd_board_st_t st;
    scd_board_st_t next_st;
    logic [31:0] reqSnap;
    logic [31:0] intRatio;
    logic [31:0] combSnap;
    logic [63:0] combWide;
    logic [31:0] combRatio;

    // RL4: internal division below limit
    assign intRatio = (st.rate != 32'h0 && st.rate < `SCD_INT_LIMIT) ? SYNC_RATE / st.rate : 32'h1;

    scd_snap snapReq (.ratio(bus.pwdata), .snapped(reqSnap));
    // A wrapped product would snap to a small divider, so an overflow saturates instead.
    assign combWide = {32'h0, intRatio} * {32'h0, reqSnap};
    assign combRatio = (combWide[63:32] != 32'h0) ? 32'hffff_ffff : combWide[31:0];
    // RL5: combined divider snaps to list
    scd_snap snapComb (.ratio(combRatio), .snapped(combSnap));

    assign bus.prdata = st.rdata;
    assign bus.pready = st.ready;
    assign bus.pslverr = st.err;
    assign sampleEn = st.en;
    assign activeDiv = st.divider;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        // RL14: one pulse per N cycles
        // RL12: counts the shared sync clock
        if (st.count + 32'h1 >= st.divider)
        begin
            next_st.count = 32'h0;
            next_st.en = 1'b1;
        end
        else
        begin
            next_st.count = st.count + 32'h1;
            next_st.en = 1'b0;
        end
        if (bus.psel && bus.penable && !st.ready)
        begin
            next_st.ready = 1'b1;
            next_st.rdata = 32'h0;
            case (bus.paddr)
                `SCD_REG_DIVIDER:
                begin
                    // RL1: divider read and write
                    if (bus.pwrite)
                    begin
                        next_st.divider = combSnap;
                        // RL9: restart keeps offset fixed
                        next_st.count = 32'h0;
                    end
                    else
                        next_st.rdata = st.divider;
                end
                `SCD_REG_STARTDELAY:
                begin
                    // RL10: start delay read only
                    if (bus.pwrite)
                        next_st.err = 1'b1;
                    else
                        next_st.rdata = fifoMode ? START_DELAY : 32'h0;
                end
                `SCD_REG_CONFIG:
                begin
                    if (bus.pwrite)
                        next_st.rate = bus.pwdata;
                    else
                        next_st.rdata = st.rate;
                end
                default:
                    next_st.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.divider <= `SCD_DIV_RESET;
            st.rate <= `SCD_RATE_RESET;
        end
        else
            st <= next_st;
    end
endmodule

// *** scd_cfg.svh ***
// Constants of the sync clock divider: register map, reset values and divider list length.
// ----------------------------------------------------------------------------
// Summary of operation
// RL1: Software reads and writes extra divider per board.
// RL2: Only listed ratios 1..2000 are ever produced.
// RL3: Controller programs divider on every synchronized board.
// RL4: Internal generation below 1 MS/s uses same divider.
// RL5: Combined divider snaps to best listed value.
// RL6: Set rate and channels before writing divider.
// RL7: Read divider back after rate setup completes.
// RL8: Fastest equal board is master, divider one.
// RL9: Non-FIFO offset fixed for given configuration.
// RL10: FIFO start delay in samples is readable.
// RL11: Slave FIFO delay is master minus slave delay.
// RL12: All boards clock from shared sync clock.
// RL13: Highest sum rate board becomes clock master.
// RL14: One enable pulse every N sync cycles.
// ----------------------------------------------------------------------------
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
`define SCD_REG_DIVIDER 32'h0000_4e48
`define SCD_REG_STARTDELAY 32'h0004_80c6
`define SCD_REG_CONFIG 32'h0000_0000
`define SCD_REG_STATUS 32'h0000_0004
`define SCD_DIV_RESET 32'h0000_0001
`define SCD_RATE_RESET 32'h0000_0000
`define SCD_INT_LIMIT 32'h000f_4240
`define SCD_DIV_COUNT 17
`define SCD_CFG_RATE_MSB 31
`define SCD_STAT_BUSY_BIT 0
`endif

// *** scd_ctrl.sv ***
// Controlling end: programs rate then divider, reads back divider and start delay.
`include "scd_cfg.svh"
module scd_ctrl
(
    input wire logic clk,
    input wire logic rst_n,
    scd_if.ctrl bus,
    input wire logic start,
    input wire logic [31:0] rateReq,
    input wire logic [31:0] divReq,
    output logic busy,
    output logic [31:0] effDiv,
    output logic [31:0] startDelay
);
    typedef struct packed {
        scd_pkg::scd_ctl_st_t phase;
        scd_pkg::scd_ctl_st_t after;
        logic sel;
        logic en;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] div;
        logic [31:0] dly;
        logic busy;
    } scd_ctrl_st_t;

    scd_ctrl_st_t st;
    scd_ctrl_st_t next_st;

    assign bus.psel = st.sel;
    assign bus.penable = st.en;
    assign bus.pwrite = st.wr;
    assign bus.paddr = st.addr;
    assign bus.pwdata = st.wdata;
    assign busy = st.busy;
    assign effDiv = st.div;
    assign startDelay = st.dly;

    always_comb
    begin
        next_st = st;
        case (st.phase)
            scd_pkg::SCD_C_IDLE:
            begin
                if (start)
                begin
                    // RL6: rate before divider
                    next_st = '{phase: scd_pkg::SCD_C_WAIT, after: scd_pkg::SCD_C_WRATE, sel: 1'b1,
                        en: 1'b0, wr: 1'b1, addr: `SCD_REG_CONFIG, wdata: rateReq, div: st.div,
                        dly: st.dly, busy: 1'b1};
                end
            end
            scd_pkg::SCD_C_WAIT:
            begin
                next_st.en = 1'b1;
                if (st.en && bus.pready)
                begin
                    next_st.en = 1'b0;
                    case (st.after)
                        scd_pkg::SCD_C_WRATE:
                        begin
                            // RL3: divider always programmed
                            next_st.after = scd_pkg::SCD_C_WDIV;
                            next_st.addr = `SCD_REG_DIVIDER;
                            next_st.wdata = divReq;
                        end
                        scd_pkg::SCD_C_WDIV:
                        begin
                            // RL7: read back effective divider
                            next_st.after = scd_pkg::SCD_C_RDIV;
                            next_st.wr = 1'b0;
                        end
                        scd_pkg::SCD_C_RDIV:
                        begin
                            next_st.div = bus.prdata;
                            next_st.after = scd_pkg::SCD_C_RDLY;
                            next_st.addr = `SCD_REG_STARTDELAY;
                        end
                        default:
                        begin
                            // RL11: host subtracts delays later
                            next_st.dly = bus.prdata;
                            next_st.sel = 1'b0;
                            next_st.busy = 1'b0;
                            next_st.phase = scd_pkg::SCD_C_IDLE;
                        end
                    endcase
                end
            end
            default:
                next_st.phase = scd_pkg::SCD_C_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end
endmodule

// *** scd_if.sv ***
// Register link between the divider board and the controlling party.
interface scd_if;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    modport board (input psel, input penable, input pwrite, input paddr, input pwdata,
                   output prdata, output pready, output pslverr);
    modport ctrl (output psel, output penable, output pwrite, output paddr, output pwdata,
                  input prdata, input pready, input pslverr);
endinterface

// *** scd_pkg.sv ***
// Types shared by the sync clock divider ends.
package scd_pkg;
    typedef logic [31:0] scd_word_t;
    typedef enum logic [1:0] {SCD_IDLE, SCD_SETUP, SCD_ACCESS} scd_apb_st_t;
    typedef enum logic [2:0] {SCD_C_IDLE, SCD_C_WRATE, SCD_C_WDIV, SCD_C_RDIV, SCD_C_RDLY, SCD_C_WAIT} scd_ctl_st_t;
endpackage

// *** scd_snap.sv ***
// Snaps a requested ratio to the best matching allowed divider value.
`include "scd_cfg.svh"
module scd_snap
(
    input wire logic [31:0] ratio,
    output logic [31:0] snapped
);
    localparam logic [11*`SCD_DIV_COUNT-1:0] LIST = {11'd2000, 11'd1000, 11'd800, 11'd500, 11'd400,
        11'd200, 11'd100, 11'd80, 11'd50, 11'd40, 11'd20, 11'd16, 11'd10, 11'd8, 11'd4, 11'd2, 11'd1};

    function automatic logic [31:0] absDiff(input logic [31:0] a, input logic [31:0] b);
        absDiff = (a > b) ? a - b : b - a;
    endfunction

    // ------------------------------------------------------------------------
    // Best match
    // ------------------------------------------------------------------------
    always_comb
    begin
        logic [31:0] cand;
        cand = 32'h0;
        snapped = 32'h1;
        // RL2: only listed ratios
        for (int i = 0; i < `SCD_DIV_COUNT; i++)
        begin
            cand = {21'h0, LIST[i*11 +: 11]};
            if (absDiff(cand, ratio) < absDiff(snapped, ratio))
                snapped = cand;
        end
    end
endmodule

// *** sync_clock_divider_tb_top.sv ***
// Bench: the controller end programs the board end over the shared register link.
module sync_clock_divider_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DLY = 32'h0000_0025;
    localparam logic [31:0] FAST = 32'h0098_9680;
    localparam logic [31:0] LIST [17] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'ha, 32'h10, 32'h14, 32'h28, 32'h32,
        32'h50, 32'h64, 32'hc8, 32'h190, 32'h1f4, 32'h320, 32'h3e8, 32'h7d0};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic fifoMode = 1'b0;
    logic [31:0] rateReq = FAST;
    logic [31:0] divReq = 32'h1;
    logic busy;
    logic sampleEn;
    logic [31:0] effDiv;
    logic [31:0] startDelay;
    logic [31:0] activeDiv;
    int miscompares = 0;
    int comparisons = 0;
    scd_if link ();
    // master sum rate sets sync speed.
    scd_board #(.START_DELAY(DLY), .SYNC_RATE(32'h0262_5a00)) scd_board_inst (.clk(clk), .rst_n(rst_n),
        .bus(link.board), .fifoMode(fifoMode), .sampleEn(sampleEn), .activeDiv(activeDiv));
    scd_ctrl scd_ctrl_inst (.clk(clk), .rst_n(rst_n), .bus(link.ctrl), .start(start), .rateReq(rateReq),
        .divReq(divReq), .busy(busy), .effDiv(effDiv), .startDelay(startDelay));
    scd_asserts scd_asserts_inst (.clk(clk), .rst_n(rst_n), .psel(link.psel), .penable(link.penable),
        .pwrite(link.pwrite), .paddr(link.paddr), .pwdata(link.pwdata), .prdata(link.prdata),
        .pready(link.pready), .pslverr(link.pslverr));
    initial
        forever #2.5 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Busy is sampled on the falling edge so the launching edge has settled.
    task automatic run_cfg(input logic [31:0] rate, input logic [31:0] div, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        rateReq <= rate;
        divReq <= div;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (busy !== 1'b0 && n < 400);
        check(effDiv, exp);
        check(activeDiv, exp);
    endtask
    task automatic test_list();
        for (int i = 0; i < 17; i++)
            run_cfg(FAST, LIST[i], LIST[i]);
    endtask
    task automatic test_snap();
        run_cfg(FAST, 32'h7, 32'h8);
        run_cfg(FAST, 32'hbb8, 32'h7d0);
        run_cfg(32'h0006_1a80, 32'h1, 32'h64);
        run_cfg(32'h0003_0d40, 32'h2, 32'h190);
        run_cfg(32'h0007_a120, 32'h4, 32'h190);
        run_cfg(32'h000f_4240, 32'h8, 32'h8);
    endtask
    task automatic test_period(input logic [31:0] div);
        int n;
        int lead;
        lead = 0;
        for (int k = 0; k < 2; k++)
        begin
            run_cfg(FAST, div, div);
            n = 0;
            while (sampleEn !== 1'b1 && n < 3000)
            begin
                @(negedge clk);
                n++;
            end
            // The same setting written twice must put the first pulse at the same place.
            if (k == 0)
                lead = n;
            else
                check(32'(n), 32'(lead));
        end
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (sampleEn !== 1'b1 && n < 3000);
        check(32'(n), div);
    endtask
    task automatic test_delay();
        @(posedge clk);
        fifoMode <= 1'b1;
        run_cfg(FAST, 32'h2, 32'h2);
        check(startDelay, DLY);
        // Master and slave share one setup here, so their resulting delay is zero.
        check(DLY - startDelay, 32'h0);
        @(posedge clk);
        fifoMode <= 1'b0;
        run_cfg(FAST, 32'h2, 32'h2);
        check(startDelay, 32'h0);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        test_list();
        test_snap();
        test_period(32'h1);
        test_period(32'h4);
        test_period(32'h64);
        test_delay();
        complete_run();
    end
    // The whole sequence needs under a thousand cycles; this limit leaves ample margin.
    initial
    begin
        repeat (50000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
